// File: src/dps_cfg.svh
// Constants for the dual-port disk reservation switch
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

// Manual selector positions
`define DPS_MODE_AUTO      2'h0
`define DPS_MODE_RES_A     2'h1
`define DPS_MODE_RES_B     2'h2

// Width of the unit-number lines
`define DPS_UNIT_W         4

// Times as printed, each in its own unit
`define DPS_REL_MIN_NS     1000
`define DPS_REL_DROP_US    500
`define DPS_SETUP_NS       200
`define DPS_FORCE_WAIT_US  500
`define DPS_SE_PULSE_MS    15
`define DPS_SE_PULSE_DIV   10
`define DPS_SE_LOW_S       1
`define DPS_TRY_NS         3000

`endif

// File: src/dps_pkg.sv
// Types for the dual-port disk reservation switch
package dps_pkg;

	// Switch states, Gray coded along idle, try, held, wait
	typedef enum logic [1:0] {
		DPS_IDLE = 2'h0,
		DPS_TRY  = 2'h1,
		DPS_HELD = 2'h3,
		DPS_WAIT = 2'h2
	} dps_state_t;

	// Lines from one controller
	typedef struct packed {
		logic [3:0] unit;
		logic       sel_en;
		logic       release_cmd;
		logic       prio;
	} dps_port_in_t;

	// Lines back to one controller
	typedef struct packed {
		logic selected;
		logic busy_with_partner;
		logic in_use_by_other_port;
		logic seek_end;
	} dps_port_out_t;

endpackage

// File: src/dps_switch.sv
// Dual-port reservation switch between two disk controllers and one drive
`timescale 1ns/1ps
`include "dps_cfg.svh"
// Notes on behaviour
// R1: Release pulse lasts at least 1.0 us
// R2: Controller drops select enable after normal release
// R3: Port-selected partner: only release command obeyed
// R4: Partner release forces reservation off, drops busy
// R5: Forcing port still selecting then takes drive
// R6: Pulsed forced release sets released port's latch
// R7: Priority forced release sets released port's latch
// R8: Unreserved: live seek end to both ports
// R9: Reserved: partner seek end frozen at start
// R10: Partner attempt: 1.5 ms low seek end later
// R11: Drive seek end low 1 s: same pulse
// R12: Unit lines lead select enable by 200 ns
// R13: Attempt forwarded, cleared without selected answer
// R14: Selected answer: latch port, store unit, relay
// R15: Partner matching stored unit gets in-use status
// R16: Hold variant: dropping select enable releases switch
// R17: Holder's priority blocks partner force and selection
// R18: Priority counts only after a successful selection
// R19: Port-selected partner priority ends holder's selection
// R20: Forcing port forwarded 500 us after release
// R21: Manual selector static positions bypass reservation
// R22: Losing simultaneous attempt waits for winner
// R23: Variant option, timers scaled from clock rate
// R24: Controller inputs double-synchronised, exact ties go to A
module dps_switch #(
	parameter bit PULSED_REL   = 1'b1, // [R23]
	parameter int CLK_HZ       = 20000000, // [R23]
	parameter int FORCE_CYC    = `DPS_FORCE_WAIT_US * (CLK_HZ / 1000000),
	parameter int SE_PULSE_CYC = `DPS_SE_PULSE_MS * (CLK_HZ / 1000) / `DPS_SE_PULSE_DIV,
	parameter int SE_LOW_CYC   = `DPS_SE_LOW_S * CLK_HZ
) (
	input  wire logic                      mclk_in,
	input  wire logic                      rst_in,
	input  wire logic [1:0]                mode_in,
	input  wire dps_pkg::dps_port_in_t     port_a_in,
	input  wire dps_pkg::dps_port_in_t     port_b_in,
	output dps_pkg::dps_port_out_t         port_a_out,
	output dps_pkg::dps_port_out_t         port_b_out,
	output logic [`DPS_UNIT_W-1:0]         drv_unit_out,
	output logic                           drv_sel_en_out,
	output logic                           drv_abort_out,
	input  wire logic                      drv_selected_in,
	input  wire logic                      drv_seek_end_in
);

	// Attempt window rounded up; long counts sized from their parameters
	localparam int TRY_CYC = (`DPS_TRY_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int TMR_W   = $clog2(FORCE_CYC + TRY_CYC + 1);
	localparam int SEP_W   = $clog2(SE_PULSE_CYC + 1);
	localparam int LOW_W   = $clog2(SE_LOW_CYC + 1);

	dps_pkg::dps_port_in_t [1:0] raw_in;
	dps_pkg::dps_port_in_t [1:0] meta_reg;
	dps_pkg::dps_port_in_t [1:0] sync_reg;
	dps_pkg::dps_port_in_t [1:0] prev_reg;
	dps_pkg::dps_port_out_t [1:0] out_w;
	dps_pkg::dps_state_t         state_reg;
	logic [1:0]                  sel_en;
	logic [1:0]                  rel_fall;
	logic [1:0]                  prio;
	logic [1:0]                  elig;
	logic [1:0]                  port_sel;
	logic [1:0]                  frl_reg;
	logic [1:0]                  se_out_reg;
	logic [1:0]                  se_out_next;
	logic [`DPS_UNIT_W-1:0]      unit [2];
	logic [`DPS_UNIT_W-1:0]      stored_unit_reg;
	logic                        owner_reg;
	logic                        partner;
	logic                        auto_mode;
	logic                        route_port;
	logic                        forced_req;
	logic                        normal_rel;
	logic                        leave_held;
	logic                        prio_held_reg;
	logic                        se_frz_reg;
	logic                        se_port_reg;
	logic                        pend_reg;
	logic                        low_hit;
	logic [TMR_W-1:0]            tmr_reg;
	logic [SEP_W-1:0]            se_cnt_reg;
	logic [LOW_W-1:0]            low_cnt_reg;

	assign raw_in[0] = port_a_in;
	assign raw_in[1] = port_b_in;
	assign port_a_out = out_w[0];
	assign port_b_out = out_w[1];

	assign auto_mode  = (mode_in == `DPS_MODE_AUTO);
	assign partner    = ~owner_reg;
	// Static positions steer a fixed port straight to the drive
	assign route_port = (mode_in == `DPS_MODE_RES_B) ? 1'b1 :
	                    (mode_in == `DPS_MODE_RES_A) ? 1'b0 : owner_reg; // [R21]

	// Per-port synchroniser, edge history, latch and status
	for (genvar p = 0; p < 2; p++) begin : g_port
		// Metastable stage only feeds the second stage
		always_ff @(posedge mclk_in or posedge rst_in) begin
			if (rst_in) begin
				meta_reg[p] <= '0;
				sync_reg[p] <= '0;
				prev_reg[p] <= '0;
			end else begin
				meta_reg[p] <= raw_in[p]; // [R24]
				sync_reg[p] <= meta_reg[p]; // [R24]
				prev_reg[p] <= sync_reg[p];
			end
		end

		assign sel_en[p]   = sync_reg[p].sel_en;
		assign unit[p]     = sync_reg[p].unit;
		assign prio[p]     = sync_reg[p].prio;
		// Release takes effect on its trailing edge
		assign rel_fall[p] = prev_reg[p].release_cmd & ~sync_reg[p].release_cmd; // [R1]
		assign elig[p]     = auto_mode & sel_en[p] & ~frl_reg[p]; // [R6] [R7]

		// Partner successfully compared against the stored unit number
		assign port_sel[p] = (state_reg == dps_pkg::DPS_HELD) && (owner_reg != p[0]) && sel_en[p] &&
		                     !frl_reg[p] && (unit[p] == stored_unit_reg); // [R15] [R18]

		// Force-released latch; setting wins over the clearing drop
		always_ff @(posedge mclk_in or posedge rst_in) begin
			if (rst_in) begin
				frl_reg[p] <= 1'b0;
			end else if (forced_req && owner_reg == p[0]) begin
				frl_reg[p] <= 1'b1; // [R6] [R7]
			end else if (!sel_en[p]) begin
				frl_reg[p] <= 1'b0;
			end
		end

		// Relay selected only to the latched port, or to the fixed port in a static position
		assign out_w[p].selected = drv_selected_in &&
		                           (auto_mode ? (state_reg == dps_pkg::DPS_HELD && owner_reg == p[0])
		                                      : (route_port == p[0])); // [R14] [R21]
		assign out_w[p].busy_with_partner    = PULSED_REL & port_sel[p]; // [R4]
		assign out_w[p].in_use_by_other_port = ~PULSED_REL & port_sel[p]; // [R15]
		assign out_w[p].seek_end             = se_out_reg[p];

		// Seek end gating, pulse overrides the frozen partner value
		always_comb begin
			se_out_next[p] = drv_seek_end_in; // [R8]
			if (PULSED_REL && se_cnt_reg != '0 && se_port_reg == p[0]) begin
				se_out_next[p] = 1'b0; // [R10]
			end else if (PULSED_REL && state_reg == dps_pkg::DPS_HELD && owner_reg != p[0]) begin
				se_out_next[p] = se_frz_reg; // [R9]
			end
		end
	end

	// Pulsed: partner release while port-selected; hold: partner priority
	always_comb begin
		forced_req = 1'b0;
		normal_rel = 1'b0;
		if (state_reg == dps_pkg::DPS_HELD && auto_mode) begin
			if (PULSED_REL) begin
				// Other partner lines are ignored while only port-selected
				forced_req = rel_fall[partner] && port_sel[partner]; // [R3] [R4]
				normal_rel = rel_fall[owner_reg];
			end else begin
				forced_req = prio[partner] && port_sel[partner] && !prio_held_reg; // [R17] [R18] [R19]
				normal_rel = !sel_en[owner_reg] && !prio_held_reg; // [R16] [R17]
			end
		end
	end

	assign leave_held = (state_reg == dps_pkg::DPS_HELD) && (forced_req || normal_rel || !auto_mode);

	// Switch state, owner, stored unit and shared timer
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg       <= dps_pkg::DPS_IDLE;
			owner_reg       <= 1'b0;
			stored_unit_reg <= '0;
			tmr_reg         <= '0;
			se_frz_reg      <= 1'b1;
		end else if (!auto_mode) begin
			state_reg <= dps_pkg::DPS_IDLE; // [R21]
			tmr_reg   <= '0;
		end else begin
			unique case (state_reg)
				dps_pkg::DPS_IDLE: begin
					tmr_reg <= '0;
					// One attempt at a time; A wins an exact tie
					if (elig[0]) begin
						state_reg <= dps_pkg::DPS_TRY; // [R22] [R24]
						owner_reg <= 1'b0;
					end else if (elig[1]) begin
						state_reg <= dps_pkg::DPS_TRY; // [R22]
						owner_reg <= 1'b1;
					end
				end
				dps_pkg::DPS_TRY: begin
					tmr_reg <= tmr_reg + 1'b1;
					// Only an answer to our own forwarded select counts, not the last holder's
					if (drv_selected_in && drv_sel_en_out) begin
						state_reg       <= dps_pkg::DPS_HELD; // [R14]
						stored_unit_reg <= unit[owner_reg]; // [R14]
						se_frz_reg      <= drv_seek_end_in; // [R9]
					end else if (!sel_en[owner_reg] || tmr_reg == TMR_W'(TRY_CYC - 1)) begin
						state_reg <= dps_pkg::DPS_IDLE; // [R13]
					end
				end
				dps_pkg::DPS_HELD: begin
					tmr_reg <= '0;
					// Pulsed force goes straight to neutral so the forcer may select
					if (forced_req && !PULSED_REL) begin
						state_reg <= dps_pkg::DPS_WAIT; // [R20]
					end else if (forced_req || normal_rel) begin
						state_reg <= dps_pkg::DPS_IDLE; // [R4] [R5] [R16]
					end
				end
				dps_pkg::DPS_WAIT: begin
					// Lets drive functions cease before the forcer is forwarded
					tmr_reg <= tmr_reg + 1'b1;
					if (tmr_reg == TMR_W'(FORCE_CYC - 1)) begin
						state_reg <= dps_pkg::DPS_IDLE; // [R20]
					end
				end
			endcase
		end
	end

	// Exclusive reservation by the holder, only once it is selected
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			prio_held_reg <= 1'b0;
		end else if (PULSED_REL || state_reg != dps_pkg::DPS_HELD || !prio[owner_reg]) begin
			prio_held_reg <= 1'b0;
		end else if (drv_selected_in) begin
			prio_held_reg <= 1'b1; // [R17] [R18]
		end
	end

	// Drive-low watch during a reservation, saturating
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			low_cnt_reg <= '0;
		end else if (state_reg != dps_pkg::DPS_HELD || drv_seek_end_in) begin
			low_cnt_reg <= '0;
		end else if (!low_hit) begin
			low_cnt_reg <= low_cnt_reg + 1'b1; // [R11]
		end
	end

	assign low_hit = (low_cnt_reg == LOW_W'(SE_LOW_CYC));

	// Remembered partner interest; the clear at release wins over setting
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_reg <= 1'b0;
		end else if (state_reg == dps_pkg::DPS_HELD && !leave_held && (sel_en[partner] || low_hit)) begin
			pend_reg <= 1'b1; // [R10] [R11]
		end else if (leave_held || state_reg != dps_pkg::DPS_HELD) begin
			pend_reg <= 1'b0;
		end
	end

	// Low-then-high seek end to the former partner
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			se_cnt_reg  <= '0;
			se_port_reg <= 1'b0;
		end else if (PULSED_REL && leave_held && (pend_reg || sel_en[partner] || low_hit)) begin
			se_cnt_reg  <= SEP_W'(SE_PULSE_CYC); // [R10] [R11]
			se_port_reg <= partner;
		end else if (se_cnt_reg != '0) begin
			se_cnt_reg <= se_cnt_reg - 1'b1;
		end
	end

	// Registered drive and seek-end outputs
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			drv_unit_out   <= '0;
			drv_sel_en_out <= 1'b0;
			drv_abort_out  <= 1'b0;
			se_out_reg     <= 2'h3;
		end else begin
			drv_unit_out   <= unit[route_port]; // [R13]
			drv_sel_en_out <= auto_mode ? ((state_reg == dps_pkg::DPS_TRY || state_reg == dps_pkg::DPS_HELD)
			                               && sel_en[owner_reg]) : sel_en[route_port]; // [R13] [R21]
			drv_abort_out  <= forced_req; // [R4]
			se_out_reg     <= se_out_next;
		end
	end

	// Checks on the switch behaviour
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	property p_tie;
		auto_mode && state_reg == dps_pkg::DPS_IDLE && elig[0] && elig[1]
			|=> state_reg == dps_pkg::DPS_TRY && owner_reg == 1'b0;
	endproperty
	a_tie: assert property (p_tie) else $error("tie not given to port A"); // [R24]

	property p_store;
		auto_mode && state_reg == dps_pkg::DPS_TRY && drv_selected_in && drv_sel_en_out
			|=> state_reg == dps_pkg::DPS_HELD && stored_unit_reg == $past(unit[owner_reg]);
	endproperty
	a_store: assert property (p_store) else $error("accepted unit not stored"); // [R14]

	property p_try_drop;
		auto_mode && state_reg == dps_pkg::DPS_TRY && !drv_selected_in && !sel_en[owner_reg]
			|=> state_reg == dps_pkg::DPS_IDLE;
	endproperty
	a_try_drop: assert property (p_try_drop) else $error("failed attempt kept reserved"); // [R13]

	property p_frl_set;
		forced_req && owner_reg == 1'b0 |=> frl_reg[0];
	endproperty
	a_frl_set: assert property (p_frl_set) else $error("force latch not set"); // [R6] [R7]

	property p_frl_block;
		state_reg == dps_pkg::DPS_IDLE && frl_reg[0] && !elig[1] |=> state_reg == dps_pkg::DPS_IDLE;
	endproperty
	a_frl_block: assert property (p_frl_block) else $error("latched port was selected"); // [R6]

	property p_busy_drop;
		forced_req |=> !out_w[$past(partner)].busy_with_partner && !out_w[$past(partner)].in_use_by_other_port;
	endproperty
	a_busy_drop: assert property (p_busy_drop) else $error("busy status kept after force"); // [R4]

	property p_status;
		state_reg == dps_pkg::DPS_HELD && owner_reg == 1'b0 && sel_en[1] && !frl_reg[1] &&
			unit[1] == stored_unit_reg |-> (out_w[1].busy_with_partner || out_w[1].in_use_by_other_port);
	endproperty
	a_status: assert property (p_status) else $error("partner status missing"); // [R15]

	property p_excl;
		!PULSED_REL && auto_mode && state_reg == dps_pkg::DPS_HELD && prio_held_reg && prio[owner_reg]
			|=> state_reg == dps_pkg::DPS_HELD;
	endproperty
	a_excl: assert property (p_excl) else $error("exclusive reservation lost"); // [R17]

	property p_wait;
		state_reg == dps_pkg::DPS_WAIT && tmr_reg != TMR_W'(FORCE_CYC - 1) && auto_mode
			|=> state_reg == dps_pkg::DPS_WAIT && !drv_sel_en_out;
	endproperty
	a_wait: assert property (p_wait) else $error("forced wait cut short"); // [R20]

	property p_pulse;
		se_cnt_reg != '0 |=> !se_out_reg[$past(se_port_reg)];
	endproperty
	a_pulse: assert property (p_pulse) else $error("seek end not held low"); // [R10]

	property p_live;
		PULSED_REL && state_reg == dps_pkg::DPS_IDLE && se_cnt_reg == '0
			|=> se_out_reg == {2{$past(drv_seek_end_in)}};
	endproperty
	a_live: assert property (p_live) else $error("live seek end not passed"); // [R8]

	property p_frozen;
		PULSED_REL && state_reg == dps_pkg::DPS_HELD && owner_reg == 1'b0 && se_cnt_reg == '0
			|=> se_out_reg[1] == $past(se_frz_reg);
	endproperty
	a_frozen: assert property (p_frozen) else $error("partner seek end not frozen"); // [R9]

	c_reserve: cover property (state_reg == dps_pkg::DPS_TRY ##1 state_reg == dps_pkg::DPS_HELD);
	c_force: cover property (forced_req);
	c_pulse: cover property (se_cnt_reg == SEP_W'(1));
	c_wait_done: cover property (state_reg == dps_pkg::DPS_WAIT ##1 state_reg == dps_pkg::DPS_IDLE);

endmodule

// File: bench/dps_drive_model.sv
// Behavioural disk drive that answers select attempts from the switch
`timescale 1ns/1ps
`include "dps_cfg.svh"
module dps_drive_model #(
	parameter logic [3:0] PLUG = 4'h5,
	parameter int         DLY  = 3
) (
	input  wire logic                   mclk_in,
	input  wire logic [`DPS_UNIT_W-1:0] unit_in,
	input  wire logic                   sel_en_in,
	output logic                        selected_out
);
	int match_cnt = 0;

	// Plug compare needs a stable match for a few cycles, like cable delay
	always_ff @(posedge mclk_in) begin
		if (sel_en_in && unit_in == PLUG) begin
			if (match_cnt < DLY) begin
				match_cnt <= match_cnt + 1;
			end
		end else begin
			match_cnt <= 0;
		end
	end

	// Deselects on the first clock edge after select enable drops
	assign selected_out = (match_cnt >= DLY);
endmodule

// File: bench/dual_port_disk_reservation_switch_test.sv
// Self-checking bench for both release builds of the reservation switch
`timescale 1ns/1ps
`include "dps_cfg.svh"
module dual_port_disk_reservation_switch_test;
	localparam logic [3:0] PLUG     = 4'h5;
	localparam int         SE_PULSE = 30;
	localparam int         SE_LOW   = 50;

	logic                   mclk_in  = 1'b0;
	logic                   rst_in   = 1'b1;
	logic [1:0]             mode_in  = `DPS_MODE_AUTO;
	logic                   seek_end = 1'b1;
	dps_pkg::dps_port_in_t  a_in     = '0;
	dps_pkg::dps_port_in_t  b_in     = '0;
	dps_pkg::dps_port_out_t a_out;
	dps_pkg::dps_port_out_t b_out;
	logic [3:0]             drv_unit;
	logic                   drv_sel_en;
	logic                   drv_abort;
	logic                   drv_sel;
	int                     error_cnt = 0;
	int                     n_checks  = 0;
	int                     cyc       = 0;
	dps_pkg::dps_port_out_t ha_out;
	dps_pkg::dps_port_out_t hb_out;
	logic [3:0]             h_unit;
	logic                   h_sel_en;
	logic                   h_abort;
	logic                   h_sel;

	dps_switch #(
		.PULSED_REL   (1'b1),
		.CLK_HZ       (20000000),
		.FORCE_CYC    (20),
		.SE_PULSE_CYC (SE_PULSE),
		.SE_LOW_CYC   (SE_LOW)
	) uut (
		.mclk_in         (mclk_in),
		.rst_in          (rst_in),
		.mode_in         (mode_in),
		.port_a_in       (a_in),
		.port_b_in       (b_in),
		.port_a_out      (a_out),
		.port_b_out      (b_out),
		.drv_unit_out    (drv_unit),
		.drv_sel_en_out  (drv_sel_en),
		.drv_abort_out   (drv_abort),
		.drv_selected_in (drv_sel),
		.drv_seek_end_in (seek_end)
	);

	dps_drive_model #(.PLUG(PLUG), .DLY(3)) drive (
		.mclk_in      (mclk_in),
		.unit_in      (drv_unit),
		.sel_en_in    (drv_sel_en),
		.selected_out (drv_sel)
	);

	// Hold-to-reserve build on the same controller lines, with its own drive
	dps_switch #(
		.PULSED_REL   (1'b0),
		.CLK_HZ       (20000000),
		.FORCE_CYC    (20),
		.SE_PULSE_CYC (SE_PULSE),
		.SE_LOW_CYC   (SE_LOW)
	) uut_hold (
		.mclk_in         (mclk_in),
		.rst_in          (rst_in),
		.mode_in         (mode_in),
		.port_a_in       (a_in),
		.port_b_in       (b_in),
		.port_a_out      (ha_out),
		.port_b_out      (hb_out),
		.drv_unit_out    (h_unit),
		.drv_sel_en_out  (h_sel_en),
		.drv_abort_out   (h_abort),
		.drv_selected_in (h_sel),
		.drv_seek_end_in (seek_end)
	);

	dps_drive_model #(.PLUG(PLUG), .DLY(3)) drive_h (
		.mclk_in      (mclk_in),
		.unit_in      (h_unit),
		.sel_en_in    (h_sel_en),
		.selected_out (h_sel)
	);

	// 50 ns clock
	always #25 mclk_in = ~mclk_in;

	// Hang guard, far above the thousand or so cycles the tests need
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Drives change only right after a rising edge
	task automatic cyc_n(input int n);
		repeat (n) @(posedge mclk_in);
	endtask

	// Outputs are looked at on the falling edge, clear of updates
	task automatic look(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	task automatic sel(input bit b, input logic [3:0] u);
		cyc_n(1);
		if (b) b_in.unit <= u; else a_in.unit <= u;
		cyc_n(5); // Unit lines lead select enable by 250 ns
		if (b) b_in.sel_en <= 1'b1; else a_in.sel_en <= 1'b1;
	endtask

	task automatic drop(input bit b);
		cyc_n(1);
		if (b) b_in.sel_en <= 1'b0; else a_in.sel_en <= 1'b0;
	endtask

	// Release pulse of 1.5 us, above the minimum width
	task automatic pulse_rel(input bit b);
		cyc_n(1);
		if (b) b_in.release_cmd <= 1'b1; else a_in.release_cmd <= 1'b1;
		cyc_n(30);
		if (b) b_in.release_cmd <= 1'b0; else a_in.release_cmd <= 1'b0;
	endtask

	task automatic wait_sel(input bit b);
		for (int i = 0; i < 100 && (b ? b_out.selected : a_out.selected) !== 1'b1; i++) look(1);
	endtask

	task automatic wait_hsel(input bit b);
		for (int i = 0; i < 100 && (b ? hb_out.selected : ha_out.selected) !== 1'b1; i++) look(1);
	endtask

	task automatic set_prio(input bit b, input bit v);
		cyc_n(1);
		if (b) b_in.prio <= v; else a_in.prio <= v;
	endtask

	// Length of the next low pulse on a port's seek end
	task automatic se_pulse(input bit b, output int n);
		n = 0;
		for (int i = 0; i < 20 && (b ? b_out.seek_end : a_out.seek_end) !== 1'b0; i++) look(1);
		while (n < 200 && (b ? b_out.seek_end : a_out.seek_end) === 1'b0) begin
			n++;
			look(1);
		end
	endtask

	// Forwarding, failed attempt, success and normal release
	task automatic t_basic();
		cyc_n(1);
		seek_end <= 1'b0;
		look(6);
		check("a seek end idle", a_out.seek_end, 8'h0);
		check("b seek end idle", b_out.seek_end, 8'h0);
		cyc_n(1);
		seek_end <= 1'b1;
		sel(0, 4'h3);
		look(10);
		check("drv sel en fwd", drv_sel_en, 8'h1);
		check("drv unit fwd", drv_unit, 8'h3);
		check("a sel bad unit", a_out.selected, 8'h0);
		drop(0);
		look(10);
		check("drv sel en clr", drv_sel_en, 8'h0);
		sel(0, PLUG);
		wait_sel(0);
		check("a selected", a_out.selected, 8'h1);
		check("drv unit", drv_unit, {4'h0, PLUG});
		check("b selected", b_out.selected, 8'h0);
		pulse_rel(0);
		drop(0); // Select enable dropped well inside 500 us
		look(10);
		check("a released", a_out.selected, 8'h0);
	endtask

	// Frozen partner seek end and the availability pulses
	task automatic t_seek();
		int n;
		sel(0, PLUG);
		wait_sel(0);
		cyc_n(1);
		seek_end <= 1'b0;
		look(6);
		check("a seek end live", a_out.seek_end, 8'h0);
		check("b seek end held", b_out.seek_end, 8'h1);
		check("h b seek end live", hb_out.seek_end, 8'h0);
		cyc_n(1);
		seek_end <= 1'b1;
		sel(1, 4'h9);
		cyc_n(10);
		drop(1);
		pulse_rel(0);
		drop(0);
		se_pulse(1, n);
		check("b avail pulse", n[7:0], 8'(SE_PULSE));
		check("a seek end", a_out.seek_end, 8'h1);
		sel(0, PLUG);
		wait_sel(0);
		cyc_n(1);
		seek_end <= 1'b0;
		cyc_n(SE_LOW + 10);
		seek_end <= 1'b1;
		pulse_rel(0);
		drop(0);
		se_pulse(1, n);
		check("b long low pulse", n[7:0], 8'(SE_PULSE));
	endtask

	// Forced release by the partner, then the released port's latch
	task automatic t_force();
		sel(0, PLUG);
		wait_sel(0);
		sel(1, PLUG);
		look(15);
		check("b busy", b_out.busy_with_partner, 8'h1);
		check("b not sel", b_out.selected, 8'h0);
		check("a kept", a_out.selected, 8'h1);
		pulse_rel(1);
		for (int i = 0; i < 20 && drv_abort !== 1'b1; i++) look(1);
		check("abort pulse", drv_abort, 8'h1);
		look(1);
		check("abort ends", drv_abort, 8'h0);
		wait_sel(1);
		check("b takes drive", b_out.selected, 8'h1);
		check("b busy off", b_out.busy_with_partner, 8'h0);
		check("a lost", a_out.selected, 8'h0);
		pulse_rel(1);
		drop(1);
		look(30);
		check("a latched", a_out.selected, 8'h0);
		check("a latched drv", drv_sel_en, 8'h0);
		drop(0);
		sel(0, PLUG);
		wait_sel(0);
		check("a after relatch", a_out.selected, 8'h1);
		pulse_rel(0);
		drop(0);
		cyc_n(10);
	endtask

	// Both ports at the same edge: A wins, B waits its turn
	task automatic t_tie();
		cyc_n(1);
		a_in.unit <= PLUG;
		b_in.unit <= PLUG;
		cyc_n(5);
		a_in.sel_en <= 1'b1;
		b_in.sel_en <= 1'b1;
		wait_sel(0);
		check("tie a wins", a_out.selected, 8'h1);
		check("tie b waits", b_out.selected, 8'h0);
		pulse_rel(0);
		drop(0);
		wait_sel(1);
		check("tie b later", b_out.selected, 8'h1);
		pulse_rel(1);
		drop(1);
		cyc_n(10);
	endtask

	// Static reserve to B ignores A and the release command
	task automatic t_static();
		cyc_n(1);
		mode_in <= `DPS_MODE_RES_B;
		sel(0, PLUG);
		look(15);
		check("static a drv", drv_sel_en, 8'h0);
		check("static a sel", a_out.selected, 8'h0);
		sel(1, PLUG);
		wait_sel(1);
		check("static b sel", b_out.selected, 8'h1);
		pulse_rel(1);
		look(10);
		check("static no rel", b_out.selected, 8'h1);
		drop(0);
		drop(1);
		cyc_n(1);
		mode_in <= `DPS_MODE_AUTO;
	endtask

	// Hold build: status, priority force and its wait, exclusive hold, drop release
	task automatic t_hold();
		sel(0, PLUG);
		wait_hsel(0);
		check("h a selected", ha_out.selected, 8'h1);
		sel(1, PLUG);
		look(15);
		check("h b in use", hb_out.in_use_by_other_port, 8'h1);
		check("h b no busy", hb_out.busy_with_partner, 8'h0);
		set_prio(1, 1'b1);
		look(4);
		check("h abort", h_abort, 8'h1);
		look(14);
		check("h a cut off", ha_out.selected, 8'h0);
		check("h wait drv", h_sel_en, 8'h0);
		check("h b waits", hb_out.selected, 8'h0);
		wait_hsel(1);
		check("h b forwarded", hb_out.selected, 8'h1);
		check("h a latched", ha_out.in_use_by_other_port, 8'h0);
		drop(0);
		sel(0, PLUG);
		set_prio(0, 1'b1);
		look(10);
		check("h b exclusive", hb_out.selected, 8'h1);
		check("h a port sel", ha_out.in_use_by_other_port, 8'h1);
		drop(1);
		look(10);
		check("h a refused", ha_out.selected, 8'h0);
		set_prio(0, 1'b0);
		set_prio(1, 1'b0);
		wait_hsel(0);
		check("h a after drop", ha_out.selected, 8'h1);
		drop(0);
		cyc_n(10);
	endtask

	// Reset held for 20 cycles, then the scenarios in turn
	initial begin
		cyc_n(20);
		rst_in <= 1'b0;
		t_basic();
		t_seek();
		t_force();
		t_tie();
		t_static();
		t_hold();
		conclude();
	end
endmodule
